// ---- src/cmpev_top.sv ----
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Function
// RL1 - keeps detecting events during wait
// RL2 - enabled interrupt ends wait
// RL3 - software disables block before wait
// RL4 - keeps comparing in light stop
// RL5 - pin output unchanged in light stop
// RL6 - light stop event flags, wakes
// RL7 - reset restores every bit
// RL8 - route bit feeds capture channel
// RL9 - routed channel ignores its pin
// RL10 - software enables reference buffer first
// RL11 - rising, falling or both edges
// RL12 - select external or reference input
// RL13 - pin enable gates result pin
// RL14 - mode field encodes edge choice
// RL15 - flag clears on write one
// RL16 - result bit live, zero when disabled
// RL17 - irq when flag and enable; the code also requires mask_en
// RL18 - result synchronised by two flops
// RL19 - edge from sample pair, one event
//////////////////////////////////////////////////////////////////////////////
module cmpev_top
  import cmpev_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // raw analog comparator output, asynchronous
  input  wire logic        comparator_raw,
  // timer channel zero pin as seen from the pad
  input  wire logic        timer_one_channel_zero_pin,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog core controls and outputs
  output logic             comparator_module_enable,
  output logic             reference_input_select,
  output logic             comparator_result_pin,
  output logic             timer_capture_in,
  output logic             compare_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // reset and synchroniser state
  logic       rst_meta_n;     // first reset stage
  logic       rst_n;          // released reset copy
  logic       res_meta;       // first result stage, read only by res_sync
  logic       res_sync;       // synchronised comparator result
  logic       res_prev;       // previous synchronised sample
  logic       pin_meta;       // first timer pin stage
  logic       pin_sync;       // synchronised timer pin
  // register state
  logic       mod_en;         // module enable
  logic       ref_sel;        // reference input select
  logic       irq_en;         // compare interrupt enable
  logic       pin_en;         // result pin enable
  logic [1:0] edge_mode;      // event edge select
  logic       event_flag;     // sticky compare event flag
  logic       mask_en;        // extra interrupt mask
  logic       route_cap;      // comparator to capture route
  // bus handling
  cmpev_wr_state_t wr_state;  // write channel state
  logic       aw_held;        // address accepted, waiting for data
  logic       w_held;         // data accepted, waiting for address
  logic [7:0] aw_addr;        // latched write address
  logic [31:0] w_data;        // latched write data
  logic [3:0] w_strb;         // latched write strobes
  logic       do_write;       // both halves present this cycle
  logic       clear_flag;     // write one to flag this cycle
  logic       compare_event;  // qualified edge this cycle
  logic       res_live;       // result gated by enable
  logic [7:0] ctrl_view;      // control register read image

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // RL18 two flop sync
  // first stage feeds only the second; the edge detector uses later stages
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_meta <= 1'b0;
      res_sync <= 1'b0;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      res_meta <= comparator_raw;
      res_sync <= res_meta;
      pin_meta <= timer_one_channel_zero_pin;
      pin_sync <= pin_meta;
    end
  end

  // RL16 result gated by enable
  assign res_live = mod_en & res_sync;

  // RL19 previous sample register
  // disabled block holds zero, so enabling never fakes a falling edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      res_prev <= 1'b0;
    else
      res_prev <= res_live;
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge qualification
  // RL11 RL14 edge mode decode
  always_comb
  begin
    case (edge_mode)
      CMPEV_MODE_FALL0: compare_event = res_prev & ~res_live;
      CMPEV_MODE_RISE:  compare_event = ~res_prev & res_live;
      CMPEV_MODE_FALL2: compare_event = res_prev & ~res_live;
      CMPEV_MODE_BOTH:  compare_event = res_prev ^ res_live;
      default:          compare_event = 1'b0;
    endcase
  end
  // RL1 RL4 no mode gating
  // wait and light stop are invisible here: detection runs on mclk alone

  //////////////////////////////////////////////////////////////////////////////
  // axi write channel
  // commit strobe: both halves latched, byte lane zero enabled
  assign do_write   = (wr_state == CMPEV_WR_IDLE) & aw_held & w_held & w_strb[0];
  // flag clear from either register that shows the flag bit
  assign clear_flag = do_write & w_data[CMPEV_FLAG_BIT]
                    & ((aw_addr == CMPEV_CTRL_ADDR) | (aw_addr == CMPEV_STAT_ADDR));

  // write handshake and response
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_state      <= CMPEV_WR_IDLE;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CMPEV_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wr_state)
        CMPEV_WR_IDLE:
        begin
          // take each half when it arrives, in either order
          if (s_axi_awvalid && !aw_held && !s_axi_awready)
          begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b1;
          end
          if (s_axi_wvalid && !w_held && !s_axi_wready)
          begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
          end
          if (aw_held && w_held)
          begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // unmapped addresses answer slave error
            s_axi_bresp  <= (aw_addr == CMPEV_CTRL_ADDR || aw_addr == CMPEV_STAT_ADDR ||
                             aw_addr == CMPEV_MASK_ADDR || aw_addr == CMPEV_ROUTE_ADDR)
                            ? CMPEV_RESP_OKAY : CMPEV_RESP_SLVERR;
            wr_state     <= CMPEV_WR_RESP;
          end
        end
        CMPEV_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state     <= CMPEV_WR_IDLE;
          end
        end
        default:
          wr_state <= CMPEV_WR_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes apply when both halves are latched and byte lane zero is strobed
  // RL7 RL12 RL13 control state
  // async reset alone returns every bit, covering exit from stop by reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mod_en    <= CMPEV_CTRL_RST[CMPEV_ENABLE_BIT];
      ref_sel   <= CMPEV_CTRL_RST[CMPEV_REFSEL_BIT];
      irq_en    <= CMPEV_CTRL_RST[CMPEV_IRQEN_BIT];
      pin_en    <= CMPEV_CTRL_RST[CMPEV_PINEN_BIT];
      edge_mode <= CMPEV_CTRL_RST[CMPEV_MODE_LSB +: 2];
      mask_en   <= CMPEV_MASK_RST;
      route_cap <= CMPEV_ROUTE_RST;
    end
    else if (do_write)
    begin
      if (aw_addr == CMPEV_CTRL_ADDR)
      begin
        mod_en    <= w_data[CMPEV_ENABLE_BIT];
        ref_sel   <= w_data[CMPEV_REFSEL_BIT];
        irq_en    <= w_data[CMPEV_IRQEN_BIT];
        pin_en    <= w_data[CMPEV_PINEN_BIT];
        edge_mode <= w_data[CMPEV_MODE_LSB +: 2];
      end
      else if (aw_addr == CMPEV_MASK_ADDR)
        mask_en   <= w_data[CMPEV_FLAG_BIT];
      else if (aw_addr == CMPEV_ROUTE_ADDR)
        route_cap <= w_data[CMPEV_ROUTE_BIT];
    end
  end

  // RL15 RL6 sticky event flag
  // a clear applies only at the write commit; a coincident event wins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      event_flag <= CMPEV_CTRL_RST[CMPEV_FLAG_BIT];
    else if (compare_event)
      event_flag <= 1'b1;
    else if (clear_flag)
      event_flag <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi read channel, one cycle after address
  assign ctrl_view = {mod_en, ref_sel, event_flag, irq_en, res_live, pin_en, edge_mode};

  // read answer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CMPEV_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid && !s_axi_arready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= CMPEV_RESP_OKAY;
      case (s_axi_araddr)
        CMPEV_CTRL_ADDR:  s_axi_rdata <= {24'h000000, ctrl_view};
        CMPEV_STAT_ADDR:  s_axi_rdata <= {26'h0000000, event_flag, 5'h00};
        CMPEV_MASK_ADDR:  s_axi_rdata <= {26'h0000000, mask_en, 5'h00};
        CMPEV_ROUTE_ADDR: s_axi_rdata <= {31'h00000000, route_cap};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= CMPEV_RESP_SLVERR;
        end
      endcase
    end
    else
      s_axi_arready <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comparator_module_enable <= 1'b0;
      reference_input_select   <= 1'b0;
      comparator_result_pin    <= 1'b0;
      timer_capture_in         <= 1'b0;
      compare_irq              <= 1'b0;
    end
    else
    begin
      comparator_module_enable <= mod_en;
      // RL12 input select
      // reference buffer enable is software's duty before selecting
      reference_input_select   <= ref_sel;
      // RL13 RL5 pin gating
      comparator_result_pin    <= pin_en & res_live;
      // RL8 RL9 capture routing
      timer_capture_in         <= route_cap ? res_live : pin_sync;
      // RL17 RL2 RL6 interrupt level
      // status bit shared with flag; mask register gates it too
      compare_irq              <= event_flag & irq_en & mask_en;
    end
  end

endmodule : cmpev_top

// ---- src/cmpev_pkg.sv ----
package cmpev_pkg;
  // register byte addresses
  localparam logic [7:0] CMPEV_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] CMPEV_STAT_ADDR   = 8'h04;
  localparam logic [7:0] CMPEV_MASK_ADDR   = 8'h08;
  localparam logic [7:0] CMPEV_ROUTE_ADDR  = 8'h0C;
  // control register field positions
  localparam int CMPEV_ENABLE_BIT   = 7;
  localparam int CMPEV_REFSEL_BIT   = 6;
  localparam int CMPEV_FLAG_BIT     = 5;
  localparam int CMPEV_IRQEN_BIT    = 4;
  localparam int CMPEV_RESULT_BIT   = 3;
  localparam int CMPEV_PINEN_BIT    = 2;
  localparam int CMPEV_MODE_LSB     = 0;
  // route register field position
  localparam int CMPEV_ROUTE_BIT    = 0;
  // reset values
  localparam logic [7:0] CMPEV_CTRL_RST  = 8'h00;
  localparam logic       CMPEV_MASK_RST  = 1'b0;
  localparam logic       CMPEV_ROUTE_RST = 1'b0;
  // edge select encodings
  localparam logic [1:0] CMPEV_MODE_FALL0 = 2'h0;
  localparam logic [1:0] CMPEV_MODE_RISE  = 2'h1;
  localparam logic [1:0] CMPEV_MODE_FALL2 = 2'h2;
  localparam logic [1:0] CMPEV_MODE_BOTH  = 2'h3;
  // axi responses
  localparam logic [1:0] CMPEV_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CMPEV_RESP_SLVERR = 2'h2;
  // write slave states
  typedef enum logic [1:0] {
    CMPEV_WR_IDLE = 2'b00,
    CMPEV_WR_RESP = 2'b01
  } cmpev_wr_state_t;
endpackage : cmpev_pkg

// ---- verification/cmpev_analog_model.sv ----
`timescale 1ns/10ps
module cmpev_analog_model (
  input  wire logic mclk,
  input  wire logic module_enable,
  input  wire logic ref_select,
  input  wire logic reference_buffer_enable,
  input  wire logic plus_above,
  input  wire logic ref_above,
  output logic      comparator_raw
);
  logic junk = 1'b0;  // unsettled output pattern
  // a powered-down core gives no valid level, so it wanders
  always_ff @(posedge mclk)
    junk <= ~junk;
  always_comb
  begin
    if (!module_enable || (ref_select && !reference_buffer_enable))
      comparator_raw = junk;
    else
      comparator_raw = ref_select ? ref_above : plus_above;
  end
endmodule : cmpev_analog_model

// ---- verification/cmpev_properties.sv ----
`timescale 1ns/10ps
module cmpev_props (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        comparator_raw,
  input wire logic        timer_one_channel_zero_pin,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        comparator_module_enable,
  input wire logic        reference_input_select,
  input wire logic        comparator_result_pin,
  input wire logic        timer_capture_in,
  input wire logic        compare_irq
);
  logic       raw_q;  // raw level at last edge
  logic [3:0] quiet;  // cycles since raw moved or a write ended
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // saturating, so a long quiet spell never wraps to a false cause
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      raw_q <= 1'b0;
      quiet <= 4'h0;
    end
    else
    begin
      raw_q <= comparator_raw;
      if (s_axi_bvalid || comparator_raw != raw_q)
        quiet <= 4'h0;
      else if (quiet != 4'hF)
        quiet <= quiet + 4'h1;
    end
  end
  ////////////////////////////////////////
  read_answer_a:
    assert property ($rose(s_axi_arready) |-> s_axi_rvalid) else $error("read data late");
  read_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  pin_gate_a:
    assert property (comparator_result_pin |-> comparator_module_enable) else $error("pin without enable");
  pin_follow_a:
    assert property ($rose(comparator_result_pin) |-> $past(comparator_raw, 3) || $past(comparator_raw, 4))
      else $error("pin rose without input");
  capture_src_a:
    assert property (timer_capture_in |-> $past(comparator_raw, 3) || $past(comparator_raw, 4)
      || $past(timer_one_channel_zero_pin, 3) || $past(timer_one_channel_zero_pin, 4))
      else $error("capture input without source");
  irq_cause_a:
    assert property ($rose(compare_irq) |-> quiet < 4'h8) else $error("irq without cause");
  irq_clear_a:
    assert property ($fell(compare_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("irq fell without write");
  ctrl_write_a:
    assert property ($changed(comparator_module_enable) || $changed(reference_input_select)
      |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("control moved without write");
endmodule : cmpev_props

bind cmpev_top cmpev_props i_cmpev_props (.*);

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import cmpev_pkg::*;
  localparam logic [31:0] EN  = 32'h1 << CMPEV_ENABLE_BIT;
  localparam logic [31:0] RS  = 32'h1 << CMPEV_REFSEL_BIT;
  localparam logic [31:0] FLG = 32'h1 << CMPEV_FLAG_BIT;
  localparam logic [31:0] IE  = 32'h1 << CMPEV_IRQEN_BIT;
  localparam logic [31:0] RES = 32'h1 << CMPEV_RESULT_BIT;
  localparam logic [31:0] PE  = 32'h1 << CMPEV_PINEN_BIT;
  logic        mclk, reset_n, comparator_raw, timer_one_channel_zero_pin, plus_gt, band_gt, buf_en;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, timer_capture_in, compare_irq;
  logic        comparator_module_enable, reference_input_select, comparator_result_pin;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, base;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          n_errors, n_checks;

  cmpev_top i_cmpev_top (.*);
  cmpev_analog_model i_cmpev_analog_model (.mclk(mclk), .module_enable(comparator_module_enable),
    .ref_select(reference_input_select), .reference_buffer_enable(buf_en), .plus_above(plus_gt),
    .ref_above(band_gt), .comparator_raw(comparator_raw));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // both write halves offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // ready follows the data, so the slave must hold its answer a cycle
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready)
        s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    chk(nm, s_axi_rdata, exp);
    chk(nm, 32'(s_axi_rresp), 32'(er));
  endtask : rchk

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk("ctrl_rst", CMPEV_CTRL_ADDR, 32'(CMPEV_CTRL_RST), CMPEV_RESP_OKAY);
    rchk("mask_rst", CMPEV_MASK_ADDR, 32'(CMPEV_MASK_RST) << 5, CMPEV_RESP_OKAY);
    rchk("route_rst", CMPEV_ROUTE_ADDR, 32'(CMPEV_ROUTE_RST), CMPEV_RESP_OKAY);
    chk("en_rst", 32'(comparator_module_enable), 32'h0);
  endtask : do_reset

  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run();
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {timer_one_channel_zero_pin, plus_gt, band_gt, buf_en} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    do_reset();
    rchk("rd_unmapped", 8'h10, 32'h0, CMPEV_RESP_SLVERR);
    axw(8'h14, 32'hFF, rs);
    chk("wr_unmapped", 32'(rs), 32'(CMPEV_RESP_SLVERR));
    axw(CMPEV_MASK_ADDR, FLG, rs);
    // every edge mode, rising then falling input
    for (int m = 0; m < 4; m++)
    begin
      base = EN | IE | PE | 32'(m);
      axw(CMPEV_CTRL_ADDR, base, rs);
      repeat (8) @(posedge mclk);
      axw(CMPEV_STAT_ADDR, FLG, rs);
      plus_gt <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("pin", 32'(comparator_result_pin), 32'h1);
      chk("irq_rise", 32'(compare_irq), 32'(m % 2));
      axw(CMPEV_STAT_ADDR, 32'h0, rs);
      rchk("rise", CMPEV_CTRL_ADDR, base | RES | ((m % 2) ? FLG : 32'h0), CMPEV_RESP_OKAY);
      axw(CMPEV_STAT_ADDR, FLG, rs);
      plus_gt <= 1'b0;
      repeat (8) @(posedge mclk);
      rchk("fall", CMPEV_CTRL_ADDR, base | ((m != 1) ? FLG : 32'h0), CMPEV_RESP_OKAY);
      axw(CMPEV_STAT_ADDR, FLG, rs);
    end
    axw(CMPEV_CTRL_ADDR, EN | 32'(CMPEV_MODE_BOTH), rs);
    plus_gt <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("pin_off", 32'(comparator_result_pin), 32'h0);
    chk("irq_off", 32'(compare_irq), 32'h0);
    rchk("both", CMPEV_CTRL_ADDR, EN | FLG | RES | 32'h3, CMPEV_RESP_OKAY);
    rchk("stat", CMPEV_STAT_ADDR, FLG, CMPEV_RESP_OKAY);
    axw(CMPEV_CTRL_ADDR, 32'h0, rs);
    repeat (8) @(posedge mclk);
    rchk("off", CMPEV_CTRL_ADDR, FLG, CMPEV_RESP_OKAY);
    axw(CMPEV_STAT_ADDR, FLG, rs);
    // buffer on before the reference is chosen
    buf_en <= 1'b1;
    plus_gt <= 1'b0;
    band_gt <= 1'b1;
    axw(CMPEV_CTRL_ADDR, EN | RS, rs);
    repeat (8) @(posedge mclk);
    axw(CMPEV_STAT_ADDR, FLG, rs);
    chk("refsel", 32'(reference_input_select), 32'h1);
    rchk("ref", CMPEV_CTRL_ADDR, EN | RS | RES, CMPEV_RESP_OKAY);
    timer_one_channel_zero_pin <= 1'b1;
    band_gt <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("cap_pin", 32'(timer_capture_in), 32'h1);
    axw(CMPEV_ROUTE_ADDR, 32'h1 << CMPEV_ROUTE_BIT, rs);
    repeat (8) @(posedge mclk);
    chk("cap_low", 32'(timer_capture_in), 32'h0);
    band_gt <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("cap_high", 32'(timer_capture_in), 32'h1);
    do_reset();
    complete_run();
  end
endmodule : testbench
